/* File: inc/dis_defs.vh */
// register offsets, field positions, reset values and constants for the drive input scaling block
`ifndef DIS_DEFS_VH
`define DIS_DEFS_VH
`define DIS_OFF_IN2_SCALE 12'h000
`define DIS_OFF_IN3_SCALE 12'h004
`define DIS_OFF_IN4_SCALE 12'h008
`define DIS_OFF_SREF_SCALE 12'h00C
`define DIS_OFF_OUT1_SCALE 12'h010
`define DIS_OFF_ENC_SCALE 12'h014
`define DIS_OFF_CONFIG 12'h018
`define DIS_OFF_STATUS 12'h01C
`define DIS_OFF_CONTROL 12'h020
`define DIS_SCALE_RST 11'h3E8
`define DIS_SCALE_MAX 11'h7CF
`define DIS_SCALE_DIV 32'h000003E8
`define DIS_ENC_SCALE_RST 16'h01A2
`define DIS_CFG_SRC_SEL 0
`define DIS_CFG_CUR_SEL 1
`define DIS_CFG_INV_SEL 2
`define DIS_CFG_OFS_SEL 3
`define DIS_CFG_IN34_INV 4
`define DIS_CFG_LOGIC_DIS 5
`define DIS_CFG_RST 6'h08
`define DIS_ST_PERMIT 0
`define DIS_ST_INCH_REV 1
`define DIS_ST_INCH_FWD 2
`define DIS_ST_RUN_REV 3
`define DIS_ST_RUN_FWD 4
`define DIS_ST_REF_ON 5
`define DIS_ST_TRIP 6
`define DIS_CTL_REF_CLR 0
`define DIS_CTL_TRIP_CLR 1
`define DIS_OPEN_LOOP_UA 32'h00000DAC
`define DIS_FULL_LOOP_UA 32'h00004E20
`define DIS_OFS_LOOP_UA 32'h00000FA0
`define DIS_ENC_DIV 32'h000F4240
`endif

/* File: rtl/dis_top.v */
// drive input scaling, reference selection, current loop and logic input handling
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "dis_defs.vh"
// =========================================
// Overview of operation
// - scale general analogue inputs by value/1000
// - speed reference scaled by reference scale/1000
// - analogue output scaled by own value/1000
// - encoder scale default for 1024 lines, 1750rpm
// - selector 0 analogue, 1 encoder reference
// - speed input voltage or current loop
// - decode four current modes, offset default 1
// - trip below 3.5mA in offset modes
// - invert bit flips inputs 3 and 4
// - monitored inputs 3, 4 keep terminal polarity
// - start only while permit input active
// - permit loss forces pre-ramp reference zero
// - permit loss stops unless ramp hold
// - input one inch reverse when logic enabled
// - input two inch forward when logic enabled
// - input three run reverse when logic enabled
// - input four run forward when logic enabled
// - run input latches reference-on flag
// - status bits follow inputs, routing free
// - logic disable defaults 0, 1 user programs
// =========================================
// register map, one aligned 32-bit word each
// 0x00 analogue input 2 scale, thousandths, 0..1999
// 0x04 analogue input 3 scale
// 0x08 analogue input 4 scale
// 0x0C speed reference scale
// 0x10 analogue output 1 scale
// 0x14 encoder scale, 16 bits
// 0x18 config: b0 encoder source, b1 current input, b2 loop invert
//      b3 4mA offset, b4 inputs 3/4 invert, b5 normal logic off
// 0x1C status: b0 permit, b1..b4 logic inputs, b5 ref on, b6 trip
// 0x20 control, write only: b0 clear ref on, b1 clear trip
// unmapped or unaligned addresses answer with slverr
// no wait states, ready in the first access cycle; analogue outputs lag their analogue inputs one cycle
// logic inputs reach the commands three cycles after the pin
module dis_top #(
	parameter DW = 11,
	parameter LOOP_W = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire signed [DW-1:0] analog_in2,
	input wire signed [DW-1:0] analog_in3,
	input wire signed [DW-1:0] analog_in4,
	input wire signed [DW-1:0] speed_in_volt,
	input wire [LOOP_W-1:0] speed_loop_ua,
	input wire signed [DW-1:0] encoder_socket_rate,
	input wire signed [DW-1:0] analog_out1_src,
	input wire start_permit_in,
	input wire logic_in_inch_rev,
	input wire logic_in_inch_fwd,
	input wire logic_in_run_rev,
	input wire logic_in_run_fwd,
	input wire ramp_hold,
	output reg signed [DW-1:0] analog_in2_dst,
	output reg signed [DW-1:0] analog_in3_dst,
	output reg signed [DW-1:0] analog_in4_dst,
	output reg signed [DW-1:0] analog_in3_mon,
	output reg signed [DW-1:0] analog_in4_mon,
	output reg signed [DW-1:0] speed_ref_mon,
	output reg signed [DW-1:0] pre_ramp_ref,
	output reg signed [DW-1:0] analog_out1,
	output reg speed_input_current_mode,
	output reg open_loop_trip,
	output reg start_enable,
	output reg motor_stop,
	output reg inch_rev_cmd,
	output reg inch_fwd_cmd,
	output reg run_rev_cmd,
	output reg run_fwd_cmd,
	output reg ref_on
);
	// signal range and current loop constants
	localparam signed [DW-1:0] SMAX = {1'b0, {(DW-1){1'b1}}};
	localparam signed [DW-1:0] SMIN = {1'b1, {(DW-1){1'b0}}};
	localparam [31:0] LOOP_FULL = `DIS_FULL_LOOP_UA;
	localparam [31:0] LOOP_OPEN = `DIS_OPEN_LOOP_UA;
	localparam [31:0] LOOP_OFS = `DIS_OFS_LOOP_UA;
	localparam [31:0] LOOP_SPAN_OFS = `DIS_FULL_LOOP_UA - `DIS_OFS_LOOP_UA;
	localparam [31:0] REF_FULL = `DIS_SCALE_DIV;
	localparam signed [31:0] ENC_DIV = `DIS_ENC_DIV;

	// product of an 11-bit signal and an 11-bit scale fits 32 bits
	// signed scale by s/1000, truncate toward zero, saturate
	function signed [DW-1:0] scale_sat;
		input signed [DW-1:0] v;
		input [10:0] s;
		reg signed [31:0] p;
		reg signed [31:0] q;
		begin
			p = v * $signed({1'b0, s});
			q = p / $signed(`DIS_SCALE_DIV);
			if (q > $signed({{(33-DW){1'b0}}, SMAX[DW-2:0]}))
				scale_sat = SMAX;
			else if (q < -$signed({{(33-DW){1'b0}}, SMAX[DW-2:0]}) - 32'sd1)
				scale_sat = SMIN;
			else
				scale_sat = q[DW-1:0];
		end
	endfunction

	// clip a scale write to the legal 0..1999 range
	function [10:0] clip_scale;
		input [31:0] w;
		begin
			if (w[31:0] > {21'h0, `DIS_SCALE_MAX})
				clip_scale = `DIS_SCALE_MAX;
			else
				clip_scale = w[10:0];
		end
	endfunction

	// polarity flip that keeps the most negative code in range
	function signed [DW-1:0] neg_sat;
		input signed [DW-1:0] v;
		begin
			if (v == SMIN)
				neg_sat = SMAX;
			else
				neg_sat = -v;
		end
	endfunction

	// =========================================
	// register file
	// configuration and scale storage
	reg [10:0] in2_scale_r, in3_scale_r, in4_scale_r, sref_scale_r, out1_scale_r;
	reg [15:0] enc_scale_r;
	reg [5:0] cfg_r;
	// sticky flags and input stages
	reg ref_on_r;
	reg trip_r;
	reg [4:0] sync1_r, sync2_r;
	// bus phase and address decode
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable;
	wire wr_en = access_ph & pwrite & pready;
	wire rd_en = setup_ph & ~pwrite;
	wire map_hit = (paddr <= `DIS_OFF_CONTROL) & (paddr[1:0] == 2'b00);
	wire ctl_hit = (paddr == `DIS_OFF_CONTROL);
	wire [10:0] wr_scale = clip_scale(pwdata);
	wire [6:0] status_w = {trip_r, ref_on_r, sync2_r};

	// apb slave: no wait states, unmapped answers slverr
	always @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			in2_scale_r <= `DIS_SCALE_RST;
			in3_scale_r <= `DIS_SCALE_RST;
			in4_scale_r <= `DIS_SCALE_RST;
			sref_scale_r <= `DIS_SCALE_RST;
			out1_scale_r <= `DIS_SCALE_RST;
			enc_scale_r <= `DIS_ENC_SCALE_RST;
			cfg_r <= `DIS_CFG_RST;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~map_hit;
			// read data is captured in the setup cycle and stands with pready
			if (rd_en) begin
				case (paddr)
				`DIS_OFF_IN2_SCALE: prdata <= {21'h0, in2_scale_r};
				`DIS_OFF_IN3_SCALE: prdata <= {21'h0, in3_scale_r};
				`DIS_OFF_IN4_SCALE: prdata <= {21'h0, in4_scale_r};
				`DIS_OFF_SREF_SCALE: prdata <= {21'h0, sref_scale_r};
				`DIS_OFF_OUT1_SCALE: prdata <= {21'h0, out1_scale_r};
				`DIS_OFF_ENC_SCALE: prdata <= {16'h0, enc_scale_r};
				`DIS_OFF_CONFIG: prdata <= {26'h0, cfg_r};
				`DIS_OFF_STATUS: prdata <= {25'h0, status_w};
				default: prdata <= 32'h00000000;
				endcase
			end
			// writes land at the access edge with ready high
			if (wr_en) begin
				case (paddr)
				`DIS_OFF_IN2_SCALE: in2_scale_r <= wr_scale;
				`DIS_OFF_IN3_SCALE: in3_scale_r <= wr_scale;
				`DIS_OFF_IN4_SCALE: in4_scale_r <= wr_scale;
				`DIS_OFF_SREF_SCALE: sref_scale_r <= wr_scale;
				`DIS_OFF_OUT1_SCALE: out1_scale_r <= wr_scale;
				`DIS_OFF_ENC_SCALE: enc_scale_r <= pwdata[15:0];
				`DIS_OFF_CONFIG: cfg_r <= pwdata[5:0];
				default: ;
				endcase
			end
		end
	end

	// =========================================
	// logic input synchronisers
	// only the second stage is read; the first may settle late
	wire [4:0] raw_in = {logic_in_run_fwd, logic_in_run_rev, logic_in_inch_fwd,
		logic_in_inch_rev, start_permit_in};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (sys_rst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= raw_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// =========================================
	// speed reference path
	wire logic_en = ~cfg_r[`DIS_CFG_LOGIC_DIS];
	wire offset_mode = cfg_r[`DIS_CFG_OFS_SEL];
	wire loop_inv = cfg_r[`DIS_CFG_INV_SEL];
	wire cur_mode = cfg_r[`DIS_CFG_CUR_SEL];
	wire src_enc = cfg_r[`DIS_CFG_SRC_SEL];
	wire in34_inv = cfg_r[`DIS_CFG_IN34_INV];
	reg signed [DW-1:0] loop_val;
	reg signed [DW-1:0] speed_sel;
	reg signed [DW-1:0] enc_ref;
	reg [31:0] ua;
	reg [31:0] span;
	reg [31:0] frac;
	reg signed [31:0] ep;

	// current loop decode to a unipolar reference
	// offset modes floor at 4mA so the reading never goes negative
	always @* begin
		ua = {{(32-LOOP_W){1'b0}}, speed_loop_ua};
		if (ua > LOOP_FULL)
			ua = LOOP_FULL;
		span = offset_mode ? LOOP_SPAN_OFS : LOOP_FULL;
		if (offset_mode & (ua < LOOP_OFS))
			ua = LOOP_OFS;
		frac = ((ua - (offset_mode ? LOOP_OFS : 32'h0)) * REF_FULL) / span;
		if (loop_inv)
			frac = REF_FULL - frac;
		loop_val = frac[DW-1:0];
	end

	// encoder rate times scale, in millionths
	// clamp keeps a fast encoder from wrapping the reference
	always @* begin
		ep = encoder_socket_rate * $signed({16'h0, enc_scale_r});
		ep = ep / ENC_DIV;
		if (ep > 32'sd1000)
			enc_ref = 11'sd1000;
		else if (ep < -32'sd1000)
			enc_ref = -11'sd1000;
		else
			enc_ref = ep[DW-1:0];
	end

	// choose reference source
	always @* begin
		if (src_enc)
			speed_sel = enc_ref;
		else if (cur_mode)
			speed_sel = loop_val;
		else
			speed_sel = speed_in_volt;
	end

	// =========================================
	// scaled values ahead of the output registers
	wire permit_s = sync2_r[`DIS_ST_PERMIT];
	wire signed [DW-1:0] in3_pol = in34_inv ? neg_sat(analog_in3) : analog_in3;
	wire signed [DW-1:0] in4_pol = in34_inv ? neg_sat(analog_in4) : analog_in4;
	wire signed [DW-1:0] in2_scaled = scale_sat(analog_in2, in2_scale_r);
	wire signed [DW-1:0] in3_scaled = scale_sat(in3_pol, in3_scale_r);
	wire signed [DW-1:0] in4_scaled = scale_sat(in4_pol, in4_scale_r);
	wire signed [DW-1:0] sref_scaled = scale_sat(speed_sel, sref_scale_r);
	wire signed [DW-1:0] out1_scaled = scale_sat(analog_out1_src, out1_scale_r);

	// =========================================
	// scaled outputs and monitors
	always @(posedge clk) begin
		if (sys_rst) begin
			analog_in2_dst <= {DW{1'b0}};
			analog_in3_dst <= {DW{1'b0}};
			analog_in4_dst <= {DW{1'b0}};
			analog_in3_mon <= {DW{1'b0}};
			analog_in4_mon <= {DW{1'b0}};
			speed_ref_mon <= {DW{1'b0}};
			pre_ramp_ref <= {DW{1'b0}};
			analog_out1 <= {DW{1'b0}};
			speed_input_current_mode <= 1'b0;
		end else begin
			analog_in2_dst <= in2_scaled;
			analog_in3_dst <= in3_scaled;
			analog_in4_dst <= in4_scaled;
			analog_in3_mon <= analog_in3;
			analog_in4_mon <= analog_in4;
			speed_ref_mon <= speed_sel;
			pre_ramp_ref <= permit_s ? sref_scaled : {DW{1'b0}};
			analog_out1 <= out1_scaled;
			speed_input_current_mode <= cur_mode;
		end
	end

	// =========================================
	// trip, permit and logic commands
	wire ref_clr = wr_en & ctl_hit & pwdata[`DIS_CTL_REF_CLR];
	wire trip_clr = wr_en & ctl_hit & pwdata[`DIS_CTL_TRIP_CLR];
	wire trip_set = cur_mode & offset_mode & ~src_enc &
		({{(32-LOOP_W){1'b0}}, speed_loop_ua} < LOOP_OPEN);
	wire run_req = logic_en & (sync2_r[`DIS_ST_RUN_REV] | sync2_r[`DIS_ST_RUN_FWD]);

	// sticky trip and reference-on latch, set beats clear
	// reference-on also drops as soon as the permit goes away
	always @(posedge clk) begin
		if (sys_rst) begin
			trip_r <= 1'b0;
			ref_on_r <= 1'b0;
		end else begin
			if (trip_set)
				trip_r <= 1'b1;
			else if (trip_clr)
				trip_r <= 1'b0;
			if (run_req & sync2_r[`DIS_ST_PERMIT])
				ref_on_r <= 1'b1;
			else if (ref_clr | ~sync2_r[`DIS_ST_PERMIT])
				ref_on_r <= 1'b0;
		end
	end

	// permit, stop and trip outputs
	always @(posedge clk) begin
		if (sys_rst) begin
			open_loop_trip <= 1'b0;
			start_enable <= 1'b0;
			motor_stop <= 1'b1;
		end else begin
			open_loop_trip <= trip_r;
			start_enable <= sync2_r[`DIS_ST_PERMIT] & ~trip_r;
			motor_stop <= ~sync2_r[`DIS_ST_PERMIT] & ~ramp_hold;
		end
	end

	// logic commands, gated by the normal-logic enable
	always @(posedge clk) begin
		if (sys_rst) begin
			inch_rev_cmd <= 1'b0;
			inch_fwd_cmd <= 1'b0;
			run_rev_cmd <= 1'b0;
			run_fwd_cmd <= 1'b0;
			ref_on <= 1'b0;
		end else begin
			inch_rev_cmd <= logic_en & sync2_r[`DIS_ST_INCH_REV];
			inch_fwd_cmd <= logic_en & sync2_r[`DIS_ST_INCH_FWD];
			run_rev_cmd <= logic_en & sync2_r[`DIS_ST_RUN_REV];
			run_fwd_cmd <= logic_en & sync2_r[`DIS_ST_RUN_FWD];
			ref_on <= ref_on_r;
		end
	end
endmodule // dis_top

/* File: verif/dis_top_properties.sv */
// concurrent checks on the ports of the drive input scaling block
`timescale 1ns/10ps
module dis_props #(
	parameter DW = 11
) (
	input wire clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire pslverr,
	input wire signed [DW-1:0] analog_in3,
	input wire signed [DW-1:0] analog_in4,
	input wire signed [DW-1:0] analog_in3_mon,
	input wire signed [DW-1:0] analog_in4_mon,
	input wire signed [DW-1:0] pre_ramp_ref,
	input wire start_permit_in,
	input wire ramp_hold,
	input wire logic_in_inch_rev,
	input wire logic_in_run_fwd,
	input wire start_enable,
	input wire motor_stop,
	input wire inch_rev_cmd,
	input wire run_fwd_cmd,
	input wire open_loop_trip,
	input wire ref_on
);
// ======================================
// bus answer timing, pass-through and command gating
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
a_ready_access: assert property (psel && !penable |=> pready)
	else $error("no ready in access phase");
a_ready_pulse: assert property (pready |=> !pready)
	else $error("ready held too long");
a_err_in_access: assert property (pslverr |-> pready && psel && penable)
	else $error("error outside access phase");
a_mon_raw: assert property (!$past(sys_rst) |-> analog_in3_mon == $past(analog_in3)
	&& analog_in4_mon == $past(analog_in4)) else $error("monitor not raw");
a_permit_start: assert property (start_permit_in [*5] ##0 !open_loop_trip |-> start_enable)
	else $error("start not enabled");
a_permit_zero: assert property ((!start_permit_in) [*5] |-> pre_ramp_ref == 0)
	else $error("reference not zero");
a_stop_no_hold: assert property ((!start_permit_in && !ramp_hold) [*5] |-> motor_stop)
	else $error("motor not stopped");
a_inch_rev_src: assert property (inch_rev_cmd |-> $past(logic_in_inch_rev, 3))
	else $error("inch reverse without input");
a_run_fwd_src: assert property (run_fwd_cmd |-> $past(logic_in_run_fwd, 3))
	else $error("run forward without input");
// main scenarios reached
c_write: cover property (psel && penable && pready && pwrite);
c_refused: cover property (pslverr);
c_trip: cover property (open_loop_trip);
c_ref_on: cover property ($rose(ref_on));
endmodule // dis_props
bind dis_top dis_props #(.DW(DW)) i_dis_props (.*);

/* File: verif/dis_field.sv */
// field terminal, loop source and encoder model
`timescale 1ns/10ps
module dis_field (
	input wire clk,
	input wire [15:0] ua_set,
	input wire signed [10:0] rate_set,
	input wire [4:0] sw_set,
	output reg [15:0] speed_loop_ua = 16'h0000,
	output reg signed [10:0] encoder_socket_rate = 11'h000,
	output reg start_permit_in = 1'b0,
	output reg logic_in_inch_rev = 1'b0,
	output reg logic_in_inch_fwd = 1'b0,
	output reg logic_in_run_rev = 1'b0,
	output reg logic_in_run_fwd = 1'b0
);
// ======================================
// terminals change after the edge; pulse rate kept under its ceiling
always @(posedge clk) begin
	speed_loop_ua <= ua_set;
	encoder_socket_rate <= (rate_set > 11'sh3E8) ? 11'sh3E8 : rate_set;
	{logic_in_run_fwd, logic_in_run_rev, logic_in_inch_fwd} <= sw_set[4:2];
	{logic_in_inch_rev, start_permit_in} <= sw_set[1:0];
end
endmodule // dis_field

/* File: verif/dis_top_bench.sv */
// self-checking bench for the drive input scaling block
`timescale 1ns/10ps
`include "dis_defs.vh"
module dis_top_bench;
// ======================================
// stimulus, partner, design and checks
reg clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, ramp_hold = 0, err;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0, q;
reg signed [10:0] analog_in2 = 0, analog_in3 = 0, analog_in4 = 0, speed_in_volt = 0;
reg signed [10:0] analog_out1_src = 0, rate_set = 0;
reg [15:0] ua_set = 0;
reg [4:0] sw_set = 0;
wire [31:0] prdata;
wire pready, pslverr, start_permit_in, logic_in_inch_rev, logic_in_inch_fwd;
wire logic_in_run_rev, logic_in_run_fwd, speed_input_current_mode, open_loop_trip;
wire start_enable, motor_stop, inch_rev_cmd, inch_fwd_cmd, run_rev_cmd, run_fwd_cmd, ref_on;
wire [15:0] speed_loop_ua;
wire signed [10:0] encoder_socket_rate, analog_in2_dst, analog_in3_dst, analog_in4_dst;
wire signed [10:0] analog_in3_mon, analog_in4_mon, speed_ref_mon, pre_ramp_ref, analog_out1;
integer mismatches = 0, cmp_count = 0, i, e2;
dis_field i_dis_field (.*);
dis_top i_dis_top (.*);
always #10 clk = ~clk;
task final_report;
	begin
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
endtask
task chk(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	end
endtask
// one transfer: setup, then access until ready is seen at an edge
task apb(input w, input [11:0] a, input [31:0] d);
	integer n;
	begin
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			mismatches = mismatches + 1;
			final_report;
		end else begin
			q = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge clk);
		end
	end
endtask
task rd(input [11:0] a, input [31:0] exp);
	begin
		apb(0, a, 0);
		chk(q, exp);
	end
endtask
task wr(input [11:0] a, input [31:0] d);
	apb(1, a, d);
endtask
task settle;
	repeat (6) @(posedge clk);
endtask
initial begin
	repeat (20) @(posedge clk);
	sys_rst <= 0;
	@(posedge clk);
	for (i = 0; i < 5; i = i + 1) rd(4 * i, 32'h3E8);
	rd(`DIS_OFF_ENC_SCALE, 32'h1A2);
	rd(`DIS_OFF_CONFIG, 32'h8);
	rd(12'h024, 0);
	chk(err, 1);
	wr(0, 32'h9C4);
	rd(0, 32'h7CF);
	wr(4, 32'h1F4);
	wr(8, 0);
	wr(12, 32'h5DC);
	wr(16, 32'hFA);
	analog_in2 <= -300;
	analog_in3 <= 7;
	analog_in4 <= -900;
	speed_in_volt <= 400;
	analog_out1_src <= -1000;
	sw_set <= 1;
	settle;
	chk(analog_in2_dst, -599);
	chk(analog_in3_dst, 3);
	chk(analog_in4_dst, 0);
	chk(speed_ref_mon, 400);
	chk(pre_ramp_ref, 600);
	chk(analog_out1, -250);
	chk(speed_input_current_mode, 0);
	chk(start_enable, 1);
	wr(`DIS_OFF_CONFIG, 32'h18);
	settle;
	chk(analog_in3_dst, -3);
	chk(analog_in3_mon, 7);
	chk(analog_in4_mon, -900);
	analog_in3 <= -1024;
	settle;
	chk(analog_in3_dst, 511);
	chk(analog_in3_mon, -1024);
	sw_set <= 5'h11;
	settle;
	chk(run_fwd_cmd, 1);
	sw_set <= 1;
	settle;
	chk(ref_on, 1);
	rd(`DIS_OFF_STATUS, 32'h21);
	sw_set <= 5'h0F;
	settle;
	chk({inch_rev_cmd, inch_fwd_cmd, run_rev_cmd}, 7);
	wr(`DIS_OFF_CONFIG, 32'h38);
	settle;
	chk({inch_rev_cmd, inch_fwd_cmd, run_rev_cmd}, 0);
	rd(`DIS_OFF_STATUS, 32'h2F);
	wr(`DIS_OFF_CONTROL, 1);
	rd(`DIS_OFF_STATUS, 32'h0F);
	chk(ref_on, 0);
	sw_set <= 0;
	settle;
	chk(pre_ramp_ref, 0);
	chk({start_enable, motor_stop}, 1);
	ramp_hold <= 1;
	settle;
	chk(motor_stop, 0);
	ramp_hold <= 0;
	ua_set <= 16'h1F40;
	for (i = 0; i < 4; i = i + 1) begin
		wr(`DIS_OFF_CONFIG, 2 | (i[0] << 2) | (i[1] << 3));
		settle;
		e2 = i[1] ? 250 : 400;
		if (i[0]) e2 = 1000 - e2;
		chk(speed_ref_mon, e2);
		chk(speed_input_current_mode, 1);
	end
	wr(`DIS_OFF_CONFIG, 2);
	ua_set <= 16'h07D0;
	settle;
	chk(open_loop_trip, 0);
	wr(`DIS_OFF_CONFIG, 32'hA);
	settle;
	chk(open_loop_trip, 1);
	ua_set <= 16'h1F40;
	wr(`DIS_OFF_CONTROL, 2);
	settle;
	chk(open_loop_trip, 0);
	wr(`DIS_OFF_ENC_SCALE, 32'hEA60);
	wr(`DIS_OFF_CONFIG, 32'h9);
	rate_set <= 500;
	settle;
	chk(speed_ref_mon, 30);
	final_report;
end
endmodule // dis_top_bench
